//--- hdl/sync_serial_port.sv
// Synchronous serial port: APB registers, FIFOs, master and slave shift engine
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
module sync_serial_port #(
    parameter int DEPTH = sync_serial_port_pkg::FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire sync_serial_port_pkg::apb_req_t apb_in,
    output sync_serial_port_pkg::apb_rsp_t apb_out,
    input wire sync_serial_port_pkg::ser_in_t ser_in,
    output sync_serial_port_pkg::ser_out_t ser_out
);
    import sync_serial_port_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] txm;
        logic [DEPTH-1:0][DATA_W-1:0] rxm;
        logic [AW-1:0] txw;
        logic [AW-1:0] txr;
        logic [AW-1:0] rxw;
        logic [AW-1:0] rxr;
        logic [AW:0] txc;
        logic [AW:0] rxc;
        ctrl_t ctrl;
        logic [7:0] pre;
        logic [7:0] scr;
        apb_rsp_t rsp;
        xfer_state_t st;
        logic ph;
        logic [6:0] pcnt;
        logic [7:0] scnt;
        logic [4:0] bits;
        logic [DATA_W-1:0] tsh;
        logic [DATA_W-1:0] rsh;
        logic overrun;
        logic armed;
        logic [2:0] sclk_s;
        logic [2:0] frm_s;
        logic [1:0] din_s;
        ser_out_t pins;
    } state_t;

    state_t q;
    state_t d;

    assign apb_out = q.rsp;
    assign ser_out = q.pins;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic setup;
        logic access;
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic half;
        logic rxbit;
        logic rise;
        logic fall;
        logic frm;
        logic cmd_master;
        logic [4:0] last_bit;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] head;
        logic [DATA_W-1:0] load;
        logic [31:0] rdata;
        setup = 1'b0;
        access = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        half = 1'b0;
        rxbit = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        frm = 1'b0;
        cmd_master = 1'b0;
        last_bit = 5'h00;
        mask = 16'h0000;
        head = 16'h0000;
        load = 16'h0000;
        rdata = 32'h0000_0000;
        d = q;

        // Pin synchronisers; only stage 1 and the history bit feed logic
        d.sclk_s = {q.sclk_s[1:0], ser_in.sclk};
        d.frm_s = {q.frm_s[1:0], ser_in.frame};
        d.din_s = {q.din_s[0], ser_in.data};
        rise = q.sclk_s[1] & ~q.sclk_s[2];
        fall = ~q.sclk_s[1] & q.sclk_s[2];
        frm = q.frm_s[1];

        // Frame length and word alignment
        cmd_master = q.ctrl.master & (q.ctrl.fmt == FMT_CMD);
        last_bit = cmd_master ? 5'(q.ctrl.size_m1) + 5'(CMD_BITS) : 5'(q.ctrl.size_m1);
        mask = 16'hFFFF >> (4'hF - q.ctrl.size_m1);
        head = q.txm[q.txr];
        if (q.txc == '0) begin
            load = 16'h0000;
        end else if (cmd_master) begin
            load = {head[CMD_BITS-1:0], 8'h00};
        end else begin
            load = head << (4'hF - q.ctrl.size_m1);
        end
        rxbit = q.ctrl.loopback ? q.tsh[DATA_W-1] : q.din_s[1];

        ////////////////////////////////////////////////////////////////////////
        // APB slave: setup cycle latches the answer, access cycle commits
        setup = apb_in.psel & ~apb_in.penable;
        access = apb_in.psel & apb_in.penable & q.rsp.pready;
        d.rsp.pready = setup;
        if (setup) begin
            d.rsp.pslverr = 1'b0;
            unique case (apb_in.paddr)
                ADDR_CTRL: rdata = {22'h0, q.ctrl};
                ADDR_RATE: rdata = {16'h0, q.scr, q.pre};
                ADDR_DATA: rdata = (q.rxc == '0) ? 32'h0 : {16'h0, q.rxm[q.rxr]};
                ADDR_STAT: begin
                    rdata[STAT_TX_EMPTY] = (q.txc == '0);
                    rdata[STAT_TX_FULL] = (q.txc == FULL_CNT);
                    rdata[STAT_RX_EMPTY] = (q.rxc == '0);
                    rdata[STAT_RX_FULL] = (q.rxc == FULL_CNT);
                    rdata[STAT_BUSY] = (q.st != ST_IDLE) | q.armed;
                    rdata[STAT_OVERRUN] = q.overrun;
                end
                default: d.rsp.pslverr = 1'b1;
            endcase
            d.rsp.prdata = rdata;
        end
        if (access & apb_in.pwrite) begin
            unique case (apb_in.paddr)
                ADDR_CTRL: begin
                    // Format and size only change while no frame is running
                    if ((q.st == ST_IDLE) & ~q.armed) begin
                        d.ctrl = ctrl_t'(apb_in.pwdata[CTRL_W-1:0]);
                        if (d.ctrl.size_m1 < SIZE_M1_MIN) begin
                            d.ctrl.size_m1 = SIZE_M1_MIN;
                        end
                    end else begin
                        d.ctrl.en = apb_in.pwdata[CTRL_W-1];
                    end
                end
                ADDR_RATE: begin
                    d.pre = apb_in.pwdata[7:0];
                    d.scr = apb_in.pwdata[15:8];
                end
                ADDR_DATA: tx_push = (q.txc != FULL_CNT);
                ADDR_STAT: begin
                    if (apb_in.pwdata[STAT_OVERRUN]) begin
                        d.overrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (access & ~apb_in.pwrite & (apb_in.paddr == ADDR_DATA)) begin
            rx_pop = (q.rxc != '0);
        end

        ////////////////////////////////////////////////////////////////////////
        // Bit clock: half period is (prescale/2) * (divider + 1) cycles
        if (q.st == ST_IDLE) begin
            d.pcnt = '0;
            d.scnt = q.scr;
        end else if (q.pcnt != '0) begin
            d.pcnt = q.pcnt - 7'h01;
        end else begin
            // Odd or too-small prescale acts as the next lower even value, at least 2
            d.pcnt = (q.pre[7:1] == '0) ? 7'h00 : q.pre[7:1] - 7'h01;
            if (q.scnt != '0) begin
                d.scnt = q.scnt - 8'h01;
            end else begin
                d.scnt = q.scr;
                half = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Master engine
        d.pins.sclk_oe = q.ctrl.en & q.ctrl.master;
        d.pins.frame_oe = q.ctrl.en & q.ctrl.master;
        d.pins.data = q.tsh[DATA_W-1];
        unique case (q.st)
            ST_IDLE: begin
                d.pins.sclk = 1'b0;
                d.pins.frame = (q.ctrl.fmt != FMT_PULSE);
                if (q.ctrl.en & q.ctrl.master & (q.txc != '0)) begin
                    d.tsh = load;
                    tx_pop = 1'b1;
                    d.bits = '0;
                    d.ph = 1'b0;
                    d.st = ST_LEAD;
                    d.pins.frame = (q.ctrl.fmt == FMT_PULSE);
                end
            end
            ST_LEAD: begin
                // SPI style: one bit of frame setup; pulse style: one clocked frame bit
                if (half) begin
                    d.ph = ~q.ph;
                    d.pins.sclk = ~q.ph & (q.ctrl.fmt == FMT_PULSE);
                    if (q.ph) begin
                        d.st = ST_SHIFT;
                        d.pins.frame = (q.ctrl.fmt != FMT_PULSE) ? 1'b0 : 1'b0;
                    end
                end
            end
            ST_SHIFT: begin
                if (half) begin
                    d.ph = ~q.ph;
                    d.pins.sclk = ~q.ph;
                    if (~q.ph & (q.ctrl.fmt != FMT_PULSE)) begin
                        d.rsh = {q.rsh[DATA_W-2:0], rxbit};
                    end
                    if (q.ph) begin
                        if (q.ctrl.fmt == FMT_PULSE) begin
                            d.rsh = {q.rsh[DATA_W-2:0], rxbit};
                        end
                        d.tsh = {q.tsh[DATA_W-2:0], 1'b0};
                        d.bits = q.bits + 5'h01;
                        if (q.bits == last_bit) begin
                            d.st = ST_TAIL;
                        end
                    end
                end
            end
            ST_TAIL: begin
                // One idle bit between frames
                if (half) begin
                    d.ph = ~q.ph;
                    if (q.ph) begin
                        rx_push = 1'b1;
                        d.st = ST_IDLE;
                        d.pins.frame = (q.ctrl.fmt != FMT_PULSE);
                    end
                end
            end
        endcase
        if (~q.ctrl.en | ~q.ctrl.master) begin
            d.st = ST_IDLE;
            d.pins.sclk = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Slave engine, driven by the synchronised external clock and frame
        if (~q.ctrl.en | q.ctrl.master) begin
            d.armed = 1'b0;
        end else if (q.ctrl.fmt == FMT_PULSE) begin
            if (fall & frm) begin
                d.armed = 1'b1;
                d.bits = '0;
                d.tsh = load;
                tx_pop = (q.txc != '0);
            end else if (fall & q.armed) begin
                d.rsh = {q.rsh[DATA_W-2:0], rxbit};
                d.tsh = {q.tsh[DATA_W-2:0], 1'b0};
                d.bits = q.bits + 5'h01;
                if (q.bits == last_bit) begin
                    rx_push = 1'b1;
                    d.armed = 1'b0;
                end
            end
        end else if (frm) begin
            d.armed = 1'b0;
            d.bits = '0;
        end else if (~q.armed) begin
            d.armed = 1'b1;
            d.tsh = load;
            tx_pop = (q.txc != '0);
        end else begin
            if (rise) begin
                d.rsh = {q.rsh[DATA_W-2:0], rxbit};
            end
            if (fall) begin
                d.tsh = {q.tsh[DATA_W-2:0], 1'b0};
                d.bits = q.bits + 5'h01;
                if (q.bits == last_bit) begin
                    // Frame held active: next word follows back to back
                    rx_push = 1'b1;
                    d.bits = '0;
                    d.tsh = load;
                    tx_pop = (q.txc != '0);
                end
            end
        end
        d.pins.data_oe = q.ctrl.en & (q.ctrl.master | (q.armed & ~q.ctrl.slave_out_off));

        ////////////////////////////////////////////////////////////////////////
        // Queues; a frame that finds the receive queue full with no data read in the same cycle is dropped
        if (tx_push) begin
            d.txm[q.txw] = apb_in.pwdata[DATA_W-1:0];
            d.txw = q.txw + 1'b1;
        end
        if (tx_pop) begin
            d.txr = q.txr + 1'b1;
        end
        if (rx_push & (q.rxc == FULL_CNT) & ~rx_pop) begin
            rx_push = 1'b0;
            d.overrun = 1'b1;
        end
        if (rx_push) begin
            d.rxm[q.rxw] = d.rsh & mask;
            d.rxw = q.rxw + 1'b1;
        end
        if (rx_pop) begin
            d.rxr = q.rxr + 1'b1;
        end
        d.txc = q.txc + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        d.rxc = q.rxc + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            q <= '0;
            q.ctrl <= ctrl_t'(CTRL_RST);
            q.pre <= PRE_RST;
            q.scr <= SCR_RST;
        end else begin
            q <= d;
        end
    end
endmodule : sync_serial_port

//--- hdl/sync_serial_port_pkg.sv
// Shared constants, register map and carrier types of the synchronous serial port
package sync_serial_port_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CMD_BITS = 8;
    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RATE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0C;

    // Status bit positions
    localparam int STAT_TX_EMPTY = 0;
    localparam int STAT_TX_FULL = 1;
    localparam int STAT_RX_EMPTY = 2;
    localparam int STAT_RX_FULL = 3;
    localparam int STAT_BUSY = 4;
    localparam int STAT_OVERRUN = 5;

    localparam int CTRL_W = 10;
    localparam logic [3:0] SIZE_M1_MIN = 4'h3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h007;
    localparam logic [7:0] PRE_RST = 8'h02;
    localparam logic [7:0] SCR_RST = 8'h00;

    typedef enum logic [1:0] {
        FMT_SPI = 2'h0,
        FMT_PULSE = 2'h1,
        FMT_CMD = 2'h2
    } frame_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LEAD = 2'h1,
        ST_SHIFT = 2'h3,
        ST_TAIL = 2'h2
    } xfer_state_t;

    // Layout matches CTRL bits 9..0
    typedef struct packed {
        logic en;
        logic loopback;
        logic slave_out_off;
        logic master;
        frame_fmt_t fmt;
        logic [3:0] size_m1;
    } ctrl_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic sclk;
        logic frame;
        logic data;
    } ser_in_t;

    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic frame;
        logic frame_oe;
        logic data;
        logic data_oe;
    } ser_out_t;
endpackage : sync_serial_port_pkg

//--- test/sync_serial_port_checker.sv
// Assertions on the serial port's bus answers and pin enables
`timescale 1ns/1ns
module sync_serial_port_checker (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire sync_serial_port_pkg::apb_req_t apb_in,
    input wire sync_serial_port_pkg::apb_rsp_t apb_out,
    input wire sync_serial_port_pkg::ser_out_t ser_out
);
    import sync_serial_port_pkg::*;
    logic setup;
    logic mapped;
    assign setup = apb_in.psel && !apb_in.penable;
    assign mapped = apb_in.paddr inside {ADDR_CTRL, ADDR_RATE, ADDR_DATA, ADDR_STAT};
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_answer;
        setup |=> apb_out.pready;
    endproperty
    a_answer: assert property (p_answer) else $error("setup not answered");
    property p_pulse;
        apb_out.pready |=> !apb_out.pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_access;
        apb_out.pready |-> apb_in.psel && apb_in.penable;
    endproperty
    a_access: assert property (p_access) else $error("pready outside access");
    property p_unmapped;
        setup && !mapped |=> apb_out.pslverr && apb_out.pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_mapped;
        setup && mapped |=> !apb_out.pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("false slave error");
    property p_oe_pair;
        ser_out.sclk_oe == ser_out.frame_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("clock and frame split");
    property p_master_data;
        ser_out.sclk_oe |-> ser_out.data_oe;
    endproperty
    a_master_data: assert property (p_master_data) else $error("master data off");
    property p_sclk_idle;
        !ser_out.sclk_oe |-> !ser_out.sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock not idle");
endmodule : sync_serial_port_checker

bind sync_serial_port sync_serial_port_checker sync_serial_port_checker_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .apb_in(apb_in), .apb_out(apb_out),
    .ser_out(ser_out));

//--- test/serial_peer_model.sv
// Behavioural serial peripheral answering frames from the port as master
`timescale 1ns/1ns
module serial_peer_model (
    input wire logic mclk_in,
    input wire logic sclk_in,
    input wire logic frame_n_in,
    input wire logic mosi_in,
    input wire logic cmd_in,
    input wire logic [4:0] size_in,
    input wire logic [15:0] reply_in,
    output logic [15:0] got_out,
    output logic miso_out
);
    int falls = 0;
    int idx;
    logic idle_bit = 1'b0;
    // Released line toggles so nobody can live on a stale bit
    always @(posedge mclk_in) idle_bit <= ~idle_bit;
    always @(negedge frame_n_in) falls = 0;
    // Follows whatever bit rate the master picks
    always @(negedge sclk_in) if (!frame_n_in) falls = falls + 1;
    always @(posedge sclk_in) if (!frame_n_in) got_out <= {got_out[14:0], mosi_in};
    // Command frames are answered only after the eight command bits
    always_comb begin
        idx = int'(size_in) + (cmd_in ? 8 : 0) - 1 - falls;
        miso_out = frame_n_in ? idle_bit : (idx >= 0 && idx < int'(size_in) && reply_in[idx[3:0]]);
    end
endmodule : serial_peer_model

//--- test/tb_sync_serial_port.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ns
module tb_sync_serial_port;
    import sync_serial_port_pkg::*;
    localparam logic [15:0] REPLY = 16'hC3A5;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    apb_req_t apb_in = '0;
    apb_rsp_t apb_out;
    ser_in_t ser_in;
    ser_out_t ser_out;
    logic miso;
    logic cmd = 1'b0;
    logic ext_frame_n = 1'b1;
    logic [4:0] size = 5'h10;
    logic [15:0] got;
    logic [31:0] rd;
    logic slverr;
    logic [31:0] hi_len = '0;
    logic [31:0] last_hi = '0;
    int num_errors = 0;
    int total_checks = 0;
    sync_serial_port sync_serial_port_i (.mclk_in(mclk_in), .reset_in(reset_in),
        .apb_in(apb_in), .apb_out(apb_out), .ser_in(ser_in), .ser_out(ser_out));
    // Released clock pin is pulled low, frame pin pulled high
    assign ser_in = {ser_out.sclk_oe & ser_out.sclk,
        ext_frame_n & (~ser_out.frame_oe | ser_out.frame), miso};
    serial_peer_model serial_peer_model_i (.mclk_in(mclk_in), .sclk_in(ser_in.sclk),
        .frame_n_in(ser_in.frame), .mosi_in(ser_out.data), .cmd_in(cmd), .size_in(size),
        .reply_in(REPLY), .got_out(got), .miso_out(miso));
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (ser_out.sclk) begin
            hi_len <= hi_len + 1;
        end else if (hi_len != 0) begin
            last_hi <= hi_len;
            hi_len <= '0;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        total_checks++;
        if (got_v !== exp_v) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got_v, exp_v);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk_in);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        slverr = apb_out.pslverr;
        chk(32'(n), 32'h1);
        apb_in <= '0;
        @(posedge mclk_in);
    endtask : apb
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STAT, '0);
            n++;
        end while (rd[b] !== v && n < 900);
        chk({31'h0, rd[b]}, {31'h0, v});
        if (rd[b] !== v) begin
            end_sim();
        end
    endtask : wait_bit
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge mclk_in);
        num_errors++;
        $display("unexpected at %0t: watchdog", $time);
        end_sim();
    end
    initial begin
        logic [31:0] w;
        logic [31:0] m;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        apb(1'b0, ADDR_CTRL, '0);
        chk(rd, 32'h7);
        apb(1'b0, ADDR_RATE, '0);
        chk(rd, 32'h2);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd, 32'h5);
        apb(1'b0, 8'h10, '0);
        chk({31'h0, slverr}, 32'h1);
        $display("test regs done");
        apb(1'b1, ADDR_RATE, 32'h0302);
        apb(1'b1, ADDR_CTRL, 32'h14F);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, ADDR_DATA, 32'h1111 * i + 32'h0F0F);
        end
        apb(1'b0, ADDR_STAT, '0);
        chk(rd, 32'h6);
        apb(1'b1, ADDR_CTRL, 32'h34F);
        wait_bit(STAT_RX_FULL, 1'b1);
        apb(1'b1, ADDR_DATA, 32'hFFFF);
        wait_bit(STAT_OVERRUN, 1'b1);
        apb(1'b1, ADDR_STAT, 32'h20);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd & 32'h2F, 32'h9);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ADDR_DATA, '0);
            chk(rd, 32'h1111 * i + 32'h0F0F);
        end
        apb(1'b0, ADDR_DATA, '0);
        chk(rd, '0);
        $display("test fifo done");
        for (int f = 0; f < 3; f++) begin
            for (int s = 3; s < 16; s += 12) begin
                w = 32'h5A3C ^ 32'(s);
                m = (32'h1 << (s + 1)) - 32'h1;
                cmd <= (f == 2);
                size <= 5'(s + 1);
                apb(1'b1, ADDR_CTRL, 32'h240 | 32'(f << 4) | (32'(f == 1) << 8) | 32'(s));
                apb(1'b1, ADDR_DATA, w);
                wait_bit(STAT_RX_EMPTY, 1'b0);
                apb(1'b0, ADDR_DATA, '0);
                chk(rd, (f == 1 ? w : {16'h0, REPLY}) & m);
                if (f == 0) begin
                    chk({16'h0, got} & m, w & m);
                    chk(last_hi, 32'h4);
                end
            end
        end
        $display("test frames done");
        apb(1'b1, ADDR_CTRL, 32'h280);
        repeat (3) @(posedge mclk_in);
        chk(32'({ser_out.sclk_oe, ser_out.frame_oe, ser_out.data_oe}), '0);
        // External master opens a frame: output must stay off while slave_out_off is set
        ext_frame_n <= 1'b0;
        repeat (5) @(posedge mclk_in);
        chk({31'h0, ser_out.data_oe}, 32'h0);
        ext_frame_n <= 1'b1;
        repeat (4) @(posedge mclk_in);
        apb(1'b1, ADDR_CTRL, 32'h200);
        ext_frame_n <= 1'b0;
        repeat (5) @(posedge mclk_in);
        chk({31'h0, ser_out.data_oe}, 32'h1);
        $display("test slave done");
        end_sim();
    end
endmodule : tb_sync_serial_port
